/* hdl/dprp_top.sv */
// ddr2 device command logic: precharge, auto precharge, refresh, power down
`timescale 1ns/10ps
module dprp_top (
  input logic clk,
  input logic sys_rst,
  input logic ddrCk,
  input logic cke,
  input logic csN,
  input logic rasN,
  input logic casN,
  input logic weN,
  input logic bankAddr0,
  input logic bankAddr1,
  input logic a10,
  input logic [2:0] addLat,
  input logic [2:0] casLat,
  input logic burst8,
  output logic [3:0] bankOpen,
  output logic [3:0] bankReady,
  output logic [3:0] autoPreStart,
  output logic prechargePd,
  output logic activePd,
  output logic selfRefresh,
  output logic dllOff,
  output logic refreshBusy,
  output dprp_pkg::dprp_row_t refreshRow
);
  import dprp_pkg::*;

  // ----------------------------------------
  // pad synchronisation and clock edge
  // ----------------------------------------
  logic [8:0] padS;
  logic ckS, ckeS, csS, rasS, casS, weS, ba0S, ba1S, a10S;
  logic ckPrev_q, ckPrev_d, ckTick;

  dprp_sync #(
    .W(9)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({ddrCk, cke, csN, rasN, casN, weN, bankAddr0, bankAddr1, a10}),
    .q(padS)
  );

  // unpack synchronised pads
  assign {ckS, ckeS, csS, rasS, casS, weS, ba0S, ba1S, a10S} = padS;
  assign ckPrev_d = ckS;
  assign ckTick = ckS && !ckPrev_q; // memory clock rise

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic [3:0] cmdCode;
  logic [1:0] bankSel;
  logic cmdLive, isPre, isRef, isAct, isRd, isWr, anyOpen;
  dprp_cnt_t halfBurst, rdDelay, wrDelay, apDelay;
  dprp_pwr_t pwr_q, pwr_d;

  // commands heard only when running with cke high
  assign cmdLive = ckTick && ckeS && (pwr_q == PW_RUN);
  assign cmdCode = {csS, rasS, casS, weS};
  assign isPre = cmdCode == CMD_PRE;
  assign isRef = cmdCode == CMD_REF;
  assign isAct = cmdCode == CMD_ACT;
  assign isRd = cmdCode == CMD_RD;
  assign isWr = cmdCode == CMD_WR;
  assign bankSel = {ba0S, ba1S};
  assign anyOpen = |bankOpen;

  // auto precharge delays in memory clocks
  assign halfBurst = burst8 ? HALF_BURST_LONG : HALF_BURST_SHORT;
  assign rdDelay = {5'h00, addLat} + halfBurst;
  assign wrDelay = {5'h00, addLat} + {5'h00, casLat} - 8'h01 + halfBurst + CK_T_WR;
  assign apDelay = isWr ? wrDelay : rdDelay;

  // ----------------------------------------
  // banks
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_bank
      dprp_bank u_bank (
        .clk(clk),
        .sys_rst(sys_rst),
        .ckTick(ckTick),
        .actIn(cmdLive && isAct && bankSel == 2'(gi)),
        .preIn(cmdLive && isPre && (a10S || bankSel == 2'(gi))),
        .apIn(cmdLive && (isRd || isWr) && a10S && bankSel == 2'(gi)),
        .apDelay(apDelay),
        .openQ(bankOpen[gi]),
        .readyQ(bankReady[gi]),
        .apStartQ(autoPreStart[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // power, refresh and dll state
  // ----------------------------------------
  dprp_cnt_t hold_q, hold_d, rfcCnt_q, rfcCnt_d;
  dprp_cnt_t refi_q, refi_d, dllCnt_q, dllCnt_d;
  dprp_row_t row_q, row_d;
  logic dllOff_q, dllOff_d, busy_q, busy_d;
  logic pdPre_q, pdPre_d, pdAct_q, pdAct_d, self_q, self_d;
  logic refLive;

  // refresh accepted only with every bank closed
  assign refLive = cmdLive && isRef && !anyOpen;

  // next state of power and refresh logic
  always_comb
  begin
    pwr_d = pwr_q;
    hold_d = hold_q;
    rfcCnt_d = rfcCnt_q;
    refi_d = refi_q;
    dllCnt_d = dllCnt_q;
    row_d = row_q;
    dllOff_d = dllOff_q;
    if (ckTick && rfcCnt_q != 8'h00)
      rfcCnt_d = rfcCnt_q - 8'h01;
    // dll relocks over stable clocks with cke high
    if (dllOff_q && pwr_q != PW_SELF && ckTick && ckeS)
    begin
      if (dllCnt_q >= CK_DLL_LOCK - 8'h01)
      begin
        dllOff_d = 1'b0;
        dllCnt_d = 8'h00;
      end
      else
        dllCnt_d = dllCnt_q + 8'h01;
    end
    unique case (pwr_q)
      PW_RUN:
      begin
        if (ckTick && !ckeS)
        begin
          if (isRef && !anyOpen)
          begin
            pwr_d = PW_SELF;
            dllOff_d = 1'b1;
            dllCnt_d = 8'h00;
            refi_d = 8'h00;
          end
          else
            pwr_d = anyOpen ? PW_PD_ACT : PW_PD_PRE;
        end
        else if (refLive)
        begin
          row_d = row_q + ROW_STEP;
          rfcCnt_d = CK_T_RFC;
        end
      end
      PW_PD_PRE, PW_PD_ACT:
      begin
        if (ckTick && ckeS)
        begin
          pwr_d = PW_EXIT;
          hold_d = CK_PD_EXIT - 8'h01;
        end
      end
      PW_EXIT:
      begin
        if (ckTick)
        begin
          if (hold_q <= 8'h01)
            pwr_d = PW_RUN;
          else
            hold_d = hold_q - 8'h01;
        end
      end
      PW_SELF:
      begin
        // internal refresh without the memory clock
        if (refi_q >= REFI_CYC - 8'h01)
        begin
          refi_d = 8'h00;
          row_d = row_q + ROW_STEP;
        end
        else
          refi_d = refi_q + 8'h01;
        if (ckeS)
        begin
          pwr_d = PW_SRX;
          hold_d = CK_T_XSNR;
        end
      end
      PW_SRX:
      begin
        if (ckTick)
        begin
          if (hold_q <= 8'h01)
            pwr_d = PW_RUN;
          else
            hold_d = hold_q - 8'h01;
        end
      end
      default:
        pwr_d = PW_RUN;
    endcase
    pdPre_d = pwr_d == PW_PD_PRE;
    pdAct_d = pwr_d == PW_PD_ACT;
    self_d = pwr_d == PW_SELF;
    busy_d = rfcCnt_d != 8'h00;
  end

  // power and refresh registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ckPrev_q <= 1'b0;
      pwr_q <= PW_RUN;
      hold_q <= 8'h00;
      rfcCnt_q <= 8'h00;
      refi_q <= 8'h00;
      dllCnt_q <= 8'h00;
      row_q <= ROW_RESET;
      dllOff_q <= 1'b0;
      busy_q <= 1'b0;
      pdPre_q <= 1'b0;
      pdAct_q <= 1'b0;
      self_q <= 1'b0;
    end
    else
    begin
      ckPrev_q <= ckPrev_d;
      pwr_q <= pwr_d;
      hold_q <= hold_d;
      rfcCnt_q <= rfcCnt_d;
      refi_q <= refi_d;
      dllCnt_q <= dllCnt_d;
      row_q <= row_d;
      dllOff_q <= dllOff_d;
      busy_q <= busy_d;
      pdPre_q <= pdPre_d;
      pdAct_q <= pdAct_d;
      self_q <= self_d;
    end
  end

  // outputs straight from registers
  assign prechargePd = pdPre_q;
  assign activePd = pdAct_q;
  assign selfRefresh = self_q;
  assign dllOff = dllOff_q;
  assign refreshBusy = busy_q;
  assign refreshRow = row_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_pdEnter;
    ckTick && !ckeS && pwr_q == PW_RUN && !(isRef && !anyOpen);
  endsequence

  sequence s_pdExit;
    ckTick && ckeS && (pwr_q == PW_PD_PRE || pwr_q == PW_PD_ACT);
  endsequence

  property p_preAll;
    @(posedge clk) disable iff (sys_rst)
    cmdLive && isPre && a10S |=> bankOpen == 4'h0;
  endproperty
  a_preAll: assert property (p_preAll) else $error("precharge all left a bank open");

  property p_preOne;
    @(posedge clk) disable iff (sys_rst)
    cmdLive && isPre && !a10S |=> !bankOpen[$past(bankSel)];
  endproperty
  a_preOne: assert property (p_preOne) else $error("selected bank still open");

  property p_pdKind;
    @(posedge clk) disable iff (sys_rst)
    s_pdEnter |=> (prechargePd == !$past(anyOpen)) && (activePd == $past(anyOpen));
  endproperty
  a_pdKind: assert property (p_pdKind) else $error("wrong power down kind");

  property p_pdIgnore;
    @(posedge clk) disable iff (sys_rst)
    (prechargePd || activePd) |=> $stable(refreshRow) && !refreshBusy;
  endproperty
  a_pdIgnore: assert property (p_pdIgnore) else $error("input acted on in power down");

  property p_pdExit;
    @(posedge clk) disable iff (sys_rst)
    s_pdExit |=> (pwr_q == PW_EXIT) && !prechargePd && !activePd && !cmdLive;
  endproperty
  a_pdExit: assert property (p_pdExit) else $error("power down exit wrong");

  property p_exitMute;
    @(posedge clk) disable iff (sys_rst)
    pwr_q == PW_EXIT && ckTick |=> ((bankOpen & ~$past(bankOpen)) == 4'h0) && $stable(refreshRow);
  endproperty
  a_exitMute: assert property (p_exitMute) else $error("command heard too soon after exit");

  property p_refRow;
    @(posedge clk) disable iff (sys_rst)
    refLive |=> refreshRow == 13'($past(refreshRow) + ROW_STEP);
  endproperty
  a_refRow: assert property (p_refRow) else $error("refresh row not advanced by two");

  property p_refBusy;
    @(posedge clk) disable iff (sys_rst)
    refLive |=> refreshBusy [*2];
  endproperty
  a_refBusy: assert property (p_refBusy) else $error("refresh busy missing");

  property p_selfEntry;
    @(posedge clk) disable iff (sys_rst)
    ckTick && !ckeS && pwr_q == PW_RUN && isRef && !anyOpen |=> selfRefresh && dllOff;
  endproperty
  a_selfEntry: assert property (p_selfEntry) else $error("self refresh not entered");
endmodule

/* pkg/dprp_pkg.sv */
// constants and types for the ddr2 precharge, refresh and power down block
package dprp_pkg;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef logic [7:0] dprp_cnt_t;
  typedef logic [12:0] dprp_row_t;
  typedef enum logic [2:0] {
    PW_RUN = 3'h0,
    PW_PD_PRE = 3'h1,
    PW_PD_ACT = 3'h2,
    PW_EXIT = 3'h3,
    PW_SELF = 3'h4,
    PW_SRX = 3'h5
  } dprp_pwr_t;

  // ----------------------------------------
  // command codes {cs, ras, cas, we}
  // ----------------------------------------
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;

  // ----------------------------------------
  // timing in memory clock cycles
  // ----------------------------------------
  localparam dprp_cnt_t CK_T_RAS = 8'h08;
  localparam dprp_cnt_t CK_T_RC = 8'h0b;
  localparam dprp_cnt_t CK_T_RP = 8'h03;
  localparam dprp_cnt_t CK_T_WR = 8'h03;
  localparam dprp_cnt_t CK_T_RFC = 8'h1a;
  localparam dprp_cnt_t CK_T_XSNR = 8'h1c;
  localparam dprp_cnt_t CK_DLL_LOCK = 8'hc8;
  localparam dprp_cnt_t CK_PD_EXIT = 8'h02;
  localparam dprp_cnt_t HALF_BURST_SHORT = 8'h02;
  localparam dprp_cnt_t HALF_BURST_LONG = 8'h04;

  // ----------------------------------------
  // self refresh interval on the system clock
  // ----------------------------------------
  localparam int T_REFI_NS = 7800;
  localparam int CLK_PERIOD_NS = 100;
  localparam dprp_cnt_t REFI_CYC = 8'(T_REFI_NS / CLK_PERIOD_NS);

  // ----------------------------------------
  // refresh row counter
  // ----------------------------------------
  localparam dprp_row_t ROW_RESET = 13'h0000;
  localparam dprp_row_t ROW_STEP = 13'h0002;
endpackage

/* hdl/dprp_sync.sv */
// two flip-flop synchroniser for pad inputs
`timescale 1ns/10ps
module dprp_sync #(
  parameter int W = 1
) (
  input logic clk,
  input logic sys_rst,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage read only by second stage
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* hdl/dprp_bank.sv */
// one bank: open state, tras/trc/trp timers and auto precharge
`timescale 1ns/10ps
module dprp_bank (
  input logic clk,
  input logic sys_rst,
  input logic ckTick,
  input logic actIn,
  input logic preIn,
  input logic apIn,
  input dprp_pkg::dprp_cnt_t apDelay,
  output logic openQ,
  output logic readyQ,
  output logic apStartQ
);
  import dprp_pkg::*;

  dprp_cnt_t rasCnt_q, rasCnt_d, rcCnt_q, rcCnt_d;
  dprp_cnt_t rpCnt_q, rpCnt_d, apCnt_q, apCnt_d;
  logic apPend_q, apPend_d, open_q, open_d;
  logic ready_q, ready_d, apStart_q, apStart_d;
  logic rasMet, apFire;

  // auto precharge waits for its delay and for tras
  // met on the tick that brings the count to its limit
  assign rasMet = rasCnt_q >= CK_T_RAS - 8'h01;
  assign apFire = apPend_q && ckTick && (apCnt_q <= 8'h01) && rasMet;

  // next state of bank timers
  always_comb
  begin
    rasCnt_d = rasCnt_q;
    rcCnt_d = rcCnt_q;
    rpCnt_d = rpCnt_q;
    apCnt_d = apCnt_q;
    apPend_d = apPend_q;
    open_d = open_q;
    if (actIn)
    begin
      rasCnt_d = 8'h00;
      rcCnt_d = 8'h00;
      open_d = 1'b1;
    end
    else
    begin
      if (ckTick && rasCnt_q < CK_T_RAS)
        rasCnt_d = rasCnt_q + 8'h01;
      if (ckTick && rcCnt_q < CK_T_RC)
        rcCnt_d = rcCnt_q + 8'h01;
    end
    if (apIn)
    begin
      apPend_d = 1'b1;
      apCnt_d = apDelay;
    end
    else if (apFire || preIn)
      apPend_d = 1'b0;
    else if (ckTick && apCnt_q != 8'h00)
      apCnt_d = apCnt_q - 8'h01;
    if (preIn || apFire)
    begin
      open_d = 1'b0;
      rpCnt_d = 8'h00;
    end
    else if (ckTick && rpCnt_q < CK_T_RP)
      rpCnt_d = rpCnt_q + 8'h01;
    apStart_d = apFire;
    ready_d = (rpCnt_d >= CK_T_RP) && (rcCnt_d >= CK_T_RC) && !open_d;
  end

  // bank registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rasCnt_q <= CK_T_RAS;
      rcCnt_q <= CK_T_RC;
      rpCnt_q <= CK_T_RP;
      apCnt_q <= 8'h00;
      apPend_q <= 1'b0;
      open_q <= 1'b0;
      ready_q <= 1'b1;
      apStart_q <= 1'b0;
    end
    else
    begin
      rasCnt_q <= rasCnt_d;
      rcCnt_q <= rcCnt_d;
      rpCnt_q <= rpCnt_d;
      apCnt_q <= apCnt_d;
      apPend_q <= apPend_d;
      open_q <= open_d;
      ready_q <= ready_d;
      apStart_q <= apStart_d;
    end
  end

  assign openQ = open_q;
  assign readyQ = ready_q;
  assign apStartQ = apStart_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_rpLock;
    @(posedge clk) disable iff (sys_rst)
    (preIn || apFire) && open_q |=> !ready_q && !open_q;
  endproperty
  a_rpLock: assert property (p_rpLock) else $error("bank ready right after close");

  property p_apRas;
    @(posedge clk) disable iff (sys_rst)
    apStart_q |-> (rasCnt_q >= CK_T_RAS) && !open_q;
  endproperty
  a_apRas: assert property (p_apRas) else $error("auto precharge before tras");
endmodule

/* bench/dprp_ctrl_model.sv */
// controller model driving the command pins, cke and the memory clock
`timescale 1ns/10ps
module dprp_ctrl_model (
  input logic clk,
  output logic ddrCk,
  output logic cke,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic bankAddr0,
  output logic bankAddr1,
  output logic a10
);
  // idle pins: clock still, chip deselected
  initial
  begin
    ddrCk = 1'b0;
    cke = 1'b1;
    {csN, rasN, casN, weN} = 4'hf;
    {bankAddr0, bankAddr1, a10} = 3'h0;
  end

  // one frame: pins set, ck rise mid frame, pins held 4 clk past it
  task automatic cmd(input logic [3:0] code, input logic [1:0] bank, input logic sel, input logic ckeLvl);
    @(posedge clk);
    {csN, rasN, casN, weN} <= code;
    {bankAddr0, bankAddr1} <= bank;
    a10 <= sel;
    cke <= ckeLvl;
    repeat (4) @(posedge clk);
    ddrCk <= 1'b1;
    repeat (4) @(posedge clk);
    ddrCk <= 1'b0;
    // deselected: flip the rest so a stale level never looks valid
    {csN, rasN, casN, weN} <= {1'b1, ~rasN, ~casN, ~weN};
    {bankAddr0, bankAddr1, a10} <= ~{bankAddr0, bankAddr1, a10};
  endtask

  // cke change with the clock stopped
  task automatic setCke(input logic lvl);
    @(posedge clk);
    cke <= lvl;
  endtask
endmodule

/* bench/dprp_tb_top.sv */
// self-checking bench for the precharge, refresh and power down block
`timescale 1ns/10ps
module dprp_tb_top;
  import dprp_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ddrCk, cke, csN, rasN, casN, weN, bankAddr0, bankAddr1, a10;
  logic [2:0] addLat = 3'h0;
  logic [2:0] casLat = 3'h3;
  logic burst8 = 1'b0;
  logic [3:0] bankOpen, bankReady, autoPreStart;
  logic prechargePd, activePd, selfRefresh, dllOff, refreshBusy;
  dprp_row_t refreshRow;
  int err_total = 0;
  int checks = 0;
  int apSeen = 0;

  // ----------------------------------------
  // clock, parts and pulse monitor
  // ----------------------------------------
  always #50 clk = ~clk;

  dprp_ctrl_model u_dprp_ctrl_model (.clk(clk), .ddrCk(ddrCk), .cke(cke), .csN(csN), .rasN(rasN),
    .casN(casN), .weN(weN), .bankAddr0(bankAddr0), .bankAddr1(bankAddr1), .a10(a10));

  dprp_top u_dprp_top (.clk(clk), .sys_rst(sys_rst), .ddrCk(ddrCk), .cke(cke), .csN(csN), .rasN(rasN),
    .casN(casN), .weN(weN), .bankAddr0(bankAddr0), .bankAddr1(bankAddr1), .a10(a10), .addLat(addLat),
    .casLat(casLat), .burst8(burst8), .bankOpen(bankOpen), .bankReady(bankReady),
    .autoPreStart(autoPreStart), .prechargePd(prechargePd), .activePd(activePd),
    .selfRefresh(selfRefresh), .dllOff(dllOff), .refreshBusy(refreshBusy), .refreshRow(refreshRow));

  // counts clocks carrying an auto precharge start pulse
  always @(posedge clk)
    if (autoPreStart !== 4'h0)
      apSeen <= apSeen + 1;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one command frame, then let the answer land
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic s, input logic k = 1'b1);
    u_dprp_ctrl_model.cmd(c, b, s, k);
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic nops(input int n);
    repeat (n) cmd(4'hf, 2'h0, 1'b0);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("bankOpen", 16'h0, bankOpen);
    chk("bankReady", 16'hf, bankReady);
    chk("refreshRow", 16'h0, refreshRow);
    chk("flags", 16'h0, {prechargePd, activePd, selfRefresh, dllOff, refreshBusy});
    $display("test reset done");
  endtask

  // each bank opened, then closed alone; then all closed by one command
  task automatic t_precharge;
    logic [3:0] exp;
    exp = 4'h0;
    for (int b = 0; b < 4; b++)
    begin
      cmd(CMD_ACT, b[1:0], 1'b0);
      exp[b] = 1'b1;
      chk("bankOpen act", {12'h0, exp}, bankOpen);
    end
    for (int b = 0; b < 4; b++)
    begin
      cmd(CMD_PRE, b[1:0], 1'b0);
      exp[b] = 1'b0;
      chk("bankOpen single", {12'h0, exp}, bankOpen);
    end
    nops(12);
    cmd(CMD_ACT, 2'h0, 1'b0);
    cmd(CMD_ACT, 2'h1, 1'b0);
    cmd(CMD_ACT, 2'h3, 1'b0);
    cmd(CMD_PRE, 2'h2, 1'b1);
    chk("bankOpen all", 16'h0, bankOpen);
    chk("bankReady0 trp", 16'h0, {15'h0, bankReady[0]});
    nops(12);
    chk("bankReady idle", 16'hf, bankReady);
    $display("test precharge done");
  endtask

  // auto precharge timing for two latency settings, plus the open-row variant
  task automatic t_autopre;
    int d;
    int ap0;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      addLat <= i[2:0];
      burst8 <= i[0];
      for (int w = 0; w < 2; w++)
      begin
        d = i + (i ? 4 : 2) + (w ? 5 : 0); // write adds cl-1 plus twr
        cmd(CMD_ACT, 2'h1, 1'b0);
        nops(10);
        ap0 = apSeen;
        cmd(w ? CMD_WR : CMD_RD, 2'h1, 1'b1);
        nops(d - 1);
        chk("open before ap", 16'h1, {15'h0, bankOpen[1]});
        nops(1);
        chk("closed at ap", 16'h0, {15'h0, bankOpen[1]});
        chk("ap pulses", 16'h1, 16'(apSeen - ap0));
        nops(12);
      end
    end
    @(posedge clk);
    addLat <= 3'h0;
    burst8 <= 1'b0;
    cmd(CMD_ACT, 2'h1, 1'b0);
    cmd(CMD_RD, 2'h1, 1'b1);
    nops(6);
    chk("tras hold", 16'h1, {15'h0, bankOpen[1]});
    nops(1);
    chk("tras release", 16'h0, {15'h0, bankOpen[1]});
    nops(12);
    cmd(CMD_ACT, 2'h1, 1'b0);
    nops(10);
    cmd(CMD_RD, 2'h1, 1'b0);
    nops(8);
    chk("row kept", 16'h1, {15'h0, bankOpen[1]});
    cmd(CMD_WR, 2'h1, 1'b0);
    nops(7);
    chk("row kept wr", 16'h1, {15'h0, bankOpen[1]});
    cmd(CMD_PRE, 2'h1, 1'b0);
    nops(12);
    $display("test autopre done");
  endtask

  task automatic t_powerdown;
    cmd(4'hf, 2'h0, 1'b0, 1'b0);
    chk("pd pre", 16'h2, {14'h0, prechargePd, activePd});
    cmd(CMD_ACT, 2'h0, 1'b0, 1'b0);
    chk("pd ignores", 16'h0, bankOpen);
    cmd(CMD_ACT, 2'h0, 1'b0);
    cmd(CMD_ACT, 2'h0, 1'b0);
    chk("exit window", 16'h0, {12'h0, bankOpen} | {14'h0, prechargePd, activePd});
    cmd(CMD_ACT, 2'h0, 1'b0);
    chk("after exit", 16'h1, bankOpen);
    nops(10);
    cmd(4'hf, 2'h0, 1'b0, 1'b0);
    chk("pd act", 16'h1, {14'h0, prechargePd, activePd});
    nops(2);
    cmd(CMD_PRE, 2'h0, 1'b0);
    chk("closed after pd", 16'h0, bankOpen);
    $display("test powerdown done");
  endtask

  task automatic t_refresh;
    dprp_row_t r;
    nops(12);
    r = refreshRow;
    cmd(CMD_REF, 2'h0, 1'b0);
    chk("row step", 16'(r + 13'h2), 16'(refreshRow));
    nops(25);
    chk("busy held", 16'h1, {15'h0, refreshBusy});
    nops(1);
    chk("busy done", 16'h0, {15'h0, refreshBusy});
    cmd(CMD_ACT, 2'h3, 1'b0);
    cmd(CMD_REF, 2'h0, 1'b0);
    chk("ref refused", 16'(r + 13'h2), 16'(refreshRow));
    nops(10);
    cmd(CMD_PRE, 2'h3, 1'b0);
    $display("test refresh done");
  endtask

  task automatic t_selfref;
    dprp_row_t r;
    int n;
    nops(12);
    cmd(CMD_REF, 2'h0, 1'b0, 1'b0);
    chk("self entry", 16'h3, {14'h0, selfRefresh, dllOff});
    r = refreshRow;
    repeat (90) @(posedge clk);
    chk("self rows", 16'(r + 13'h2), 16'(refreshRow));
    u_dprp_ctrl_model.setCke(1'b1);
    n = 0;
    while (selfRefresh !== 1'b0 && n < 10)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 10)
    begin
      err_total++;
      $display("CHECK FAILED selfRefresh exit expected 0 seen %b", selfRefresh);
      return;
    end
    cmd(CMD_ACT, 2'h0, 1'b0);
    chk("txsnr ignores", 16'h0, bankOpen);
    nops(26);
    cmd(CMD_ACT, 2'h0, 1'b0);
    chk("txsnr last", 16'h0, bankOpen);
    nops(171);
    chk("dll locking", 16'h1, {15'h0, dllOff});
    nops(1);
    chk("dll locked", 16'h0, {15'h0, dllOff});
    cmd(CMD_ACT, 2'h0, 1'b0);
    chk("after self", 16'h1, bankOpen);
    $display("test selfref done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_precharge();
    t_autopre();
    t_powerdown();
    t_refresh();
    t_selfref();
    close_out();
  end
endmodule
